// [hw/lcb_consts.vh]
// Constants for the coprocessor bus access control block.
// Function
// - Tenure timer limits bus mastership time.
// - Rest timer sets least wait before re-request.
// - Timers programmed apart; trigger source selectable.
// - Internal mode: grant time exceeds tenure, release.
// - External mode: throttle input starts tenure timer.
// - During port strobe, data is slave control.
// - Legacy mode: 24-bit addresses, one 64-Kbyte segment.
// - Segmented: 32-bit, one segment; linear unrestricted.
// - Big- and little-endian byte order supported.
// - Float bus outputs when not holding bus.
// - Address release request floats address bus.
// - Attention strobe triggers control block re-examination.
// - Port access: alternate pointer, dump, reset, self-test.
`ifndef LCB_CONSTS_VH
`define LCB_CONSTS_VH

// Register byte offsets.
`define LCB_REG_CTRL 8'h00
`define LCB_REG_TENURE 8'h04
`define LCB_REG_REST 8'h08
`define LCB_REG_SEGBASE 8'h0C
`define LCB_REG_STATUS 8'h10
`define LCB_REG_ALTPTR 8'h14
`define LCB_REG_ATTNCNT 8'h18

// Control register fields.
`define LCB_CTRL_EXTTRIG 0
`define LCB_CTRL_MODE_LO 1
`define LCB_CTRL_MODE_HI 2
`define LCB_CTRL_BIGEND 3

// Status register fields.
`define LCB_STAT_STATE_LO 0
`define LCB_STAT_STATE_HI 1
`define LCB_STAT_REQ 2
`define LCB_STAT_TENRUN 3
`define LCB_STAT_RESTRUN 4
`define LCB_STAT_ATTN 8

// Addressing modes.
`define LCB_MODE_LEGACY 2'h0
`define LCB_MODE_SEGMENT 2'h1
`define LCB_MODE_LINEAR 2'h2

// Port access commands in data bits 3:0.
`define LCB_PORT_RESET 4'h0
`define LCB_PORT_SELFTEST 4'h1
`define LCB_PORT_ALTPTR 4'h2
`define LCB_PORT_DUMP 4'h3

// Reset values.
`define LCB_CTRL_RST 4'h0
`define LCB_TENURE_RST 16'h0040
`define LCB_REST_RST 16'h0010
`define LCB_SEGBASE_RST 32'h0000_0000

// Timer width.
`define LCB_TMR_W 16

`endif

// [hw/lcb_cycle_timer.v]
// Down-counting clock-cycle timer used for the tenure and rest limits.
`timescale 1ns/1ns
`include "lcb_consts.vh"

module lcb_cycle_timer (
    input wire clk,                         // system clock
    input wire rst_b,                       // async reset, active low
    input wire start,                       // load and run
    input wire stop,                        // abandon the count
    input wire [`LCB_TMR_W-1:0] loadValue,  // programmed cycles
    output wire running,                    // timer counting
    output wire expired                     // last counted cycle
);

    reg [`LCB_TMR_W-1:0] count_r;
    reg running_r;

    assign running = running_r;
    assign expired = running_r && (count_r == `LCB_TMR_W'h0001);

    // A programmed zero counts as one cycle so the timer always ends.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= `LCB_TMR_W'h0000;
            running_r <= 1'b0;
        end else if (start) begin
            count_r <= (loadValue == `LCB_TMR_W'h0000) ? `LCB_TMR_W'h0001 : loadValue;
            running_r <= 1'b1;
        end else if (stop || expired) begin
            running_r <= 1'b0;
        end else if (running_r) begin
            count_r <= count_r - `LCB_TMR_W'h0001;
        end
    end

endmodule

// [hw/lcb_access_ctrl.v]
// Bus access control of a LAN coprocessor sharing a 32-bit processor bus.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "lcb_consts.vh"

module lcb_access_ctrl (
    input wire clk,                  // system bus clock, 10 MHz
    input wire rst_b,                // async reset, active low
    input wire [7:0] regAddr,        // register byte address
    input wire [31:0] regWrData,     // register write data
    input wire regWr,                // register write strobe
    input wire regRd,                // register read strobe
    output reg [31:0] regRdData,     // read data, cycle after strobe
    input wire xferPending,          // engine has bus work queued
    input wire [31:0] coreAddr,      // engine address
    input wire [31:0] coreWrData,    // engine write data
    input wire busGrantIn,           // bus grant from processor
    input wire throttleTriggerIn,    // external throttle trigger
    input wire attentionStrobeN,     // channel attention, active low
    input wire coprocResetIn,        // hardware reset from glue
    input wire slavePortStrobeN,     // slave port strobe, active low
    input wire [31:0] busDataIn,     // bus data input
    input wire addrReleaseReq,       // address release request
    output wire busRequest,          // bus hold request
    output reg [31:0] busAddrOut,    // bus address out
    output wire busAddrOutEnN,       // address drive enable, low drives
    output reg [31:0] busDataOut,    // bus data out
    output wire busDataOutEnN,       // data/control drive enable, low drives
    output reg scbCheckReq,          // pulse: re-read control block
    output reg selfTestReq,          // pulse: run self-test
    output reg swResetReq,           // pulse: software reset
    output reg dumpReq               // pulse: run dump command
);

    // ------------------------------------------------------------
    // State encoding
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_REQ = 2'h1;
    localparam [1:0] ST_OWN = 2'h2;
    localparam [1:0] ST_REST = 2'h3;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [3:0] ctrl_r;
    reg [15:0] tenureVal_r;
    reg [15:0] restVal_r;
    reg [31:0] segBase_r;
    reg [31:0] altPtr_r;
    reg [31:0] attnCount_r;
    reg attnPending_r;
    reg attnSeen_r;
    reg trigSeen_r;
    reg portSeen_r;
    reg tenureStart;
    reg restStart;
    wire tenureRun;
    wire tenureDone;
    wire restRun;
    wire restDone;
    wire extTrig;
    wire [1:0] addrMode;
    wire bigEnd;
    wire attnEdge;
    wire trigEdge;
    wire portEdge;
    wire resetAll;
    wire owning;

    assign extTrig = ctrl_r[`LCB_CTRL_EXTTRIG];
    assign addrMode = ctrl_r[`LCB_CTRL_MODE_HI:`LCB_CTRL_MODE_LO];
    assign bigEnd = ctrl_r[`LCB_CTRL_BIGEND];
    assign attnEdge = !attentionStrobeN && !attnSeen_r;
    assign trigEdge = throttleTriggerIn && !trigSeen_r;
    assign portEdge = !slavePortStrobeN && !portSeen_r;

    // A software reset by port access restarts the arbiter like the pin does.
    assign resetAll = coprocResetIn || swResetReq;
    assign owning = (state_r == ST_OWN) && busGrantIn;

    // ------------------------------------------------------------
    // Throttle timers
    // ------------------------------------------------------------
    lcb_cycle_timer u_tenure (
        .clk(clk),
        .rst_b(rst_b),
        .start(tenureStart),
        .stop(resetAll || (state_r != ST_OWN)),
        .loadValue(tenureVal_r),
        .running(tenureRun),
        .expired(tenureDone)
    );

    lcb_cycle_timer u_rest (
        .clk(clk),
        .rst_b(rst_b),
        .start(restStart),
        .stop(resetAll),
        .loadValue(restVal_r),
        .running(restRun),
        .expired(restDone)
    );

    // ------------------------------------------------------------
    // Arbitration state machine
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        tenureStart = 1'b0;
        restStart = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (xferPending) begin
                    state_nxt = ST_REQ;
                end
            end
            ST_REQ: begin
                if (busGrantIn) begin
                    state_nxt = ST_OWN;
                    // Internal mode measures grant time from its first cycle.
                    tenureStart = !extTrig;
                end
            end
            ST_OWN: begin
                if (extTrig && trigEdge && !tenureRun) begin
                    tenureStart = 1'b1;
                end
                if (tenureDone || !xferPending) begin
                    state_nxt = ST_REST;
                    restStart = 1'b1;
                end
            end
            ST_REST: begin
                if (restDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (resetAll) begin
            state_nxt = ST_IDLE;
            tenureStart = 1'b0;
            restStart = 1'b0;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Request stays low in rest and is dropped in the same cycle the limit ends.
    assign busRequest = (state_r == ST_REQ) ||
                        ((state_r == ST_OWN) && !tenureDone && xferPending);

    // ------------------------------------------------------------
    // Bus drive enables
    // ------------------------------------------------------------
    assign busDataOutEnN = !owning;
    assign busAddrOutEnN = !owning || addrReleaseReq;

    // ------------------------------------------------------------
    // Address formation and byte order
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busAddrOut <= 32'h0000_0000;
            busDataOut <= 32'h0000_0000;
        end else begin
            case (addrMode)
                `LCB_MODE_LEGACY: begin
                    busAddrOut <= {8'h00, segBase_r[23:16], coreAddr[15:0]};
                end
                `LCB_MODE_SEGMENT: begin
                    busAddrOut <= {segBase_r[31:16], coreAddr[15:0]};
                end
                `LCB_MODE_LINEAR: begin
                    busAddrOut <= coreAddr;
                end
                default: begin
                    busAddrOut <= coreAddr;
                end
            endcase
            if (bigEnd) begin
                busDataOut <= {coreWrData[7:0], coreWrData[15:8],
                               coreWrData[23:16], coreWrData[31:24]};
            end else begin
                busDataOut <= coreWrData;
            end
        end
    end

    // ------------------------------------------------------------
    // Attention, throttle and port strobes
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            attnSeen_r <= 1'b0;
            trigSeen_r <= 1'b0;
            portSeen_r <= 1'b0;
            scbCheckReq <= 1'b0;
            selfTestReq <= 1'b0;
            swResetReq <= 1'b0;
            dumpReq <= 1'b0;
            altPtr_r <= 32'h0000_0000;
            attnCount_r <= 32'h0000_0000;
        end else begin
            attnSeen_r <= !attentionStrobeN;
            trigSeen_r <= throttleTriggerIn;
            portSeen_r <= !slavePortStrobeN;
            scbCheckReq <= attnEdge;
            if (attnEdge) begin
                attnCount_r <= attnCount_r + 32'h0000_0001;
            end
            selfTestReq <= 1'b0;
            swResetReq <= 1'b0;
            dumpReq <= 1'b0;
            // Data on the bus is a command word, never a transfer word, here.
            if (portEdge) begin
                case (busDataIn[3:0])
                    `LCB_PORT_RESET: begin
                        swResetReq <= 1'b1;
                    end
                    `LCB_PORT_SELFTEST: begin
                        selfTestReq <= 1'b1;
                        altPtr_r <= {busDataIn[31:4], 4'h0};
                    end
                    `LCB_PORT_ALTPTR: begin
                        altPtr_r <= {busDataIn[31:4], 4'h0};
                    end
                    `LCB_PORT_DUMP: begin
                        dumpReq <= 1'b1;
                        altPtr_r <= {busDataIn[31:4], 4'h0};
                    end
                    default: begin
                        altPtr_r <= altPtr_r;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `LCB_CTRL_RST;
            tenureVal_r <= `LCB_TENURE_RST;
            restVal_r <= `LCB_REST_RST;
            segBase_r <= `LCB_SEGBASE_RST;
            attnPending_r <= 1'b0;
        end else begin
            if (regWr) begin
                case (regAddr)
                    `LCB_REG_CTRL: begin
                        ctrl_r <= regWrData[3:0];
                    end
                    `LCB_REG_TENURE: begin
                        tenureVal_r <= regWrData[15:0];
                    end
                    `LCB_REG_REST: begin
                        restVal_r <= regWrData[15:0];
                    end
                    `LCB_REG_SEGBASE: begin
                        segBase_r <= regWrData;
                    end
                    default: begin
                        segBase_r <= segBase_r;
                    end
                endcase
            end
            // A new attention in the clearing cycle keeps the flag set.
            if (attnEdge) begin
                attnPending_r <= 1'b1;
            end else if (regWr && (regAddr == `LCB_REG_STATUS) &&
                         regWrData[`LCB_STAT_ATTN]) begin
                attnPending_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                `LCB_REG_CTRL: begin
                    regRdData <= {28'h000_0000, ctrl_r};
                end
                `LCB_REG_TENURE: begin
                    regRdData <= {16'h0000, tenureVal_r};
                end
                `LCB_REG_REST: begin
                    regRdData <= {16'h0000, restVal_r};
                end
                `LCB_REG_SEGBASE: begin
                    regRdData <= segBase_r;
                end
                `LCB_REG_STATUS: begin
                    regRdData <= {23'h00_0000, attnPending_r, 3'h0, restRun, tenureRun,
                                  busRequest, state_r};
                end
                `LCB_REG_ALTPTR: begin
                    regRdData <= altPtr_r;
                end
                `LCB_REG_ATTNCNT: begin
                    regRdData <= attnCount_r;
                end
                default: begin
                    regRdData <= 32'h0000_0000;
                end
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule

// [tb/lcb_access_ctrl_properties.sv]
// Port-level assertions for the bus access control block.
`timescale 1ns/1ns
module lcb_properties (
    input wire clk, // clock
    input wire rst_b, // reset
    input wire busGrantIn, // grant
    input wire coprocResetIn, // hard reset
    input wire attentionStrobeN, // attention
    input wire slavePortStrobeN, // port strobe
    input wire [31:0] busDataIn, // bus data
    input wire addrReleaseReq, // address release
    input wire busRequest, // request
    input wire busAddrOutEnN, // address enable
    input wire busDataOutEnN, // data enable
    input wire scbCheckReq, // attention pulse
    input wire selfTestReq, // self-test pulse
    input wire swResetReq, // reset pulse
    input wire dumpReq // dump pulse
);
    // ----
    // Assertions
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_float_free: assert property (!busGrantIn |-> busDataOutEnN && busAddrOutEnN)
        else $error("bus driven without grant");
    a_addr_release: assert property (addrReleaseReq |-> busAddrOutEnN)
        else $error("address driven during release");
    a_own_drive: assert property (busRequest && busGrantIn && $past(busRequest)
        && $past(busGrantIn) && !coprocResetIn |-> !busDataOutEnN)
        else $error("owner not driving");
    a_rest_quiet: assert property ($fell(busRequest) && !busDataOutEnN
        && !coprocResetIn |=> !busRequest [*2]) else $error("request during rest");
    a_attn_pulse: assert property ($fell(attentionStrobeN) |=> scbCheckReq)
        else $error("attention missed");
    a_attn_once: assert property (scbCheckReq |=> !scbCheckReq)
        else $error("attention pulse too long");
    a_port_reset: assert property ($fell(slavePortStrobeN) && busDataIn[3:0] == 4'h0
        |=> swResetReq && !selfTestReq && !dumpReq) else $error("port reset wrong");
    a_port_test: assert property ($fell(slavePortStrobeN) && busDataIn[3:0] == 4'h1
        |=> selfTestReq && !swResetReq && !dumpReq) else $error("port self-test wrong");
    a_port_ptr: assert property ($fell(slavePortStrobeN) && busDataIn[3:0] == 4'h2
        |=> !selfTestReq && !swResetReq && !dumpReq) else $error("port pointer wrong");
    a_port_dump: assert property ($fell(slavePortStrobeN) && busDataIn[3:0] == 4'h3
        |=> dumpReq && !swResetReq && !selfTestReq) else $error("port dump wrong");
endmodule

bind lcb_access_ctrl lcb_properties i_props (.clk(clk), .rst_b(rst_b),
    .busGrantIn(busGrantIn), .coprocResetIn(coprocResetIn),
    .attentionStrobeN(attentionStrobeN), .slavePortStrobeN(slavePortStrobeN),
    .busDataIn(busDataIn), .addrReleaseReq(addrReleaseReq), .busRequest(busRequest),
    .busAddrOutEnN(busAddrOutEnN), .busDataOutEnN(busDataOutEnN), .scbCheckReq(scbCheckReq),
    .selfTestReq(selfTestReq), .swResetReq(swResetReq), .dumpReq(dumpReq));

// [tb/lcb_host_model.sv]
// Host-side model: grants the bus and produces the glue strobes.
`timescale 1ns/1ns
module lcb_host_model (
    input wire clk, // clock
    input wire busRequest, // hold request
    input wire [1:0] grantLag, // grant delay
    output reg busGrantIn = 1'b0, // grant
    output reg throttleTriggerIn = 1'b0, // throttle
    output reg attentionStrobeN = 1'b1, // attention
    output reg coprocResetIn = 1'b0, // hard reset
    output reg slavePortStrobeN = 1'b1, // port strobe
    output reg [31:0] busDataIn = 32'h0000_0000, // data bus
    output wire ownerSelects // memory and data select lines
);
    reg [1:0] lag = 2'h0;
    // Both select lines go high while the block has asked for the bus and holds the grant.
    assign ownerSelects = busRequest && busGrantIn;
    // This host keeps no cache of shared structures, so no invalidation is driven.
    reg portReq = 1'b0;
    reg [31:0] portWord = 32'h0000_0000;
    // ----
    // Grant, port strobe and data bus
    // ----
    always @(posedge clk) begin
        if (!busRequest) begin
            busGrantIn <= 1'b0;
            lag <= grantLag;
        end else if (lag != 2'h0) begin
            lag <= lag - 2'h1;
        end else begin
            busGrantIn <= 1'b1;
        end
        slavePortStrobeN <= !portReq;
        // A released bus toggles so stale data is never mistaken for a command.
        busDataIn <= portReq ? portWord : ~busDataIn;
        if (portReq)
            portReq <= 1'b0;
    end
    task glue(input [31:0] d, input on);
        begin
            @(posedge clk);
            if (!on) begin
                attentionStrobeN <= 1'b1;
                coprocResetIn <= 1'b0;
            end else if (!busGrantIn && d[0]) begin
                coprocResetIn <= 1'b1;
            end else if (!busGrantIn) begin
                attentionStrobeN <= 1'b0;
            end
        end
    endtask
    task port(input [31:0] d);
        begin
            @(posedge clk);
            if (!busRequest) begin
                portWord <= d;
                portReq <= 1'b1;
            end
            repeat (2) @(posedge clk);
        end
    endtask
    task throttle(input v);
        begin
            @(posedge clk);
            throttleTriggerIn <= v;
        end
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the bus access control block.
`timescale 1ns/1ns
`include "lcb_consts.vh"
module testbench;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] regAddr = 8'h00;
    reg [31:0] regWrData = 32'h0000_0000;
    reg regWr = 1'b0;
    reg regRd = 1'b0;
    reg xferPending = 1'b0;
    reg [31:0] coreAddr = 32'h1357_2468;
    reg [31:0] coreWrData = 32'h1122_3344;
    reg addrReleaseReq = 1'b0;
    reg [1:0] grantLag = 2'h0;
    wire [31:0] regRdData, busAddrOut, busDataOut, busDataIn;
    wire busGrantIn, throttleTriggerIn, attentionStrobeN, coprocResetIn, slavePortStrobeN;
    wire ownerSelects;
    wire busRequest, busAddrOutEnN, busDataOutEnN, scbCheckReq, selfTestReq, swResetReq, dumpReq;
    reg [31:0] v;
    reg [31:0] rv;
    integer nMismatch = 0;
    integer samplesChecked = 0;
    integer i;
    integer j;
    integer k;
    always #50 clk = ~clk;
    lcb_access_ctrl i_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .xferPending(xferPending),
        .coreAddr(coreAddr), .coreWrData(coreWrData), .busGrantIn(busGrantIn),
        .throttleTriggerIn(throttleTriggerIn), .attentionStrobeN(attentionStrobeN),
        .coprocResetIn(coprocResetIn), .slavePortStrobeN(slavePortStrobeN),
        .busDataIn(busDataIn), .addrReleaseReq(addrReleaseReq), .busRequest(busRequest),
        .busAddrOut(busAddrOut), .busAddrOutEnN(busAddrOutEnN), .busDataOut(busDataOut),
        .busDataOutEnN(busDataOutEnN), .scbCheckReq(scbCheckReq), .selfTestReq(selfTestReq),
        .swResetReq(swResetReq), .dumpReq(dumpReq));
    lcb_host_model i_host (.clk(clk), .busRequest(busRequest), .grantLag(grantLag),
        .busGrantIn(busGrantIn), .throttleTriggerIn(throttleTriggerIn),
        .attentionStrobeN(attentionStrobeN), .coprocResetIn(coprocResetIn),
        .slavePortStrobeN(slavePortStrobeN), .busDataIn(busDataIn),
        .ownerSelects(ownerSelects));
    // ----
    // Tasks
    // ----
    task summarize;
        begin
            $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
            if (nMismatch == 0 && samplesChecked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            samplesChecked = samplesChecked + 1;
            if (got !== exp) begin
                nMismatch = nMismatch + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task bound(input integer c, input integer lim);
        begin
            if (c >= lim) begin
                chk("wait", 32'h0000_0000, 32'h0000_0001);
                summarize;
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            regAddr <= a;
            regWrData <= d;
            regWr <= 1'b1;
            @(posedge clk);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp, input string what);
        begin
            @(posedge clk);
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge clk);
            regRd <= 1'b0;
            @(negedge clk);
            rv = regRdData;
            if (what != "")
                chk(what, exp, rv);
        end
    endtask
    task waitIdle;
        begin
            rv = 32'h0000_0001;
            for (j = 0; j < 200 && rv[1:0] !== 2'h0; j = j + 1)
                rd(`LCB_REG_STATUS, 32'h0000_0000, "");
            bound(j, 200);
        end
    endtask
    // Counts cycles the block drives the bus, starting at the current cycle.
    task countOwn;
        begin
            for (k = 0; k < 300 && busDataOutEnN === 1'b0; k = k + 1)
                @(negedge clk);
            bound(k, 300);
        end
    endtask
    task waitOwn;
        begin
            for (j = 0; j < 100 && busDataOutEnN !== 1'b0; j = j + 1)
                @(negedge clk);
            bound(j, 100);
        end
    endtask
    task ownRun(input [15:0] tn, input [15:0] rs);
        begin
            wr(`LCB_REG_TENURE, {16'h0000, tn});
            wr(`LCB_REG_REST, {16'h0000, rs});
            xferPending <= 1'b1;
            waitOwn;
            countOwn;
            chk("tenure", (tn == 16'h0000) ? 32'h0000_0001 : {16'h0000, tn}, k);
            for (k = 0; k < 300 && busRequest === 1'b0; k = k + 1)
                @(negedge clk);
            chk("rest", (rs == 16'h0000) ? 32'h0000_0002 : {16'h0000, rs} + 1, k);
            @(posedge clk);
            xferPending <= 1'b0;
            waitIdle;
        end
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(`LCB_REG_CTRL, 32'h0000_0000, "ctrl");
        rd(`LCB_REG_TENURE, 32'h0000_0040, "tenure reg");
        rd(`LCB_REG_REST, 32'h0000_0010, "rest reg");
        wr(`LCB_REG_ATTNCNT, 32'h0000_00FF);
        rd(`LCB_REG_ATTNCNT, 32'h0000_0000, "attn count");
        rd(8'h1C, 32'h0000_0000, "unmapped");
        ownRun(16'h0040, 16'h0010);
        ownRun(16'h0000, 16'h0000);
        grantLag = 2'h3;
        ownRun(16'h0005, 16'h0003);
        grantLag = 2'h0;
        ownRun(16'h0003, 16'h0002);
        wr(`LCB_REG_CTRL, 32'h0000_0001);
        xferPending <= 1'b1;
        waitOwn;
        repeat (8) @(negedge clk);
        chk("untriggered", 32'h0000_0000, {31'h0, busDataOutEnN});
        chk("selects", 32'h0000_0001, {31'h0, ownerSelects});
        @(posedge clk);
        addrReleaseReq <= 1'b1;
        @(negedge clk);
        chk("release", 32'h0000_0002, {30'h0, busAddrOutEnN, busDataOutEnN});
        @(posedge clk);
        addrReleaseReq <= 1'b0;
        i_host.throttle(1'b1);
        @(negedge clk);
        countOwn;
        chk("triggered", 32'h0000_0004, k);
        i_host.throttle(1'b0);
        xferPending <= 1'b0;
        waitIdle;
        for (i = 0; i < 4; i = i + 1) begin
            v = 32'h1234_5670 + (i << 8) + i;
            i_host.port(v);
            @(negedge clk);
            chk("port", {29'h0, i == 0, i == 1, i == 3}, {29'h0, swResetReq, selfTestReq, dumpReq});
            if (i != 0)
                rd(`LCB_REG_ALTPTR, v & 32'hFFFF_FFF0, "pointer");
        end
        i_host.glue(32'h0000_0000, 1'b1);
        k = 0;
        repeat (4) begin
            @(negedge clk);
            k = k + scbCheckReq;
        end
        chk("attn pulses", 32'h0000_0001, k);
        i_host.glue(32'h0000_0000, 1'b0);
        rd(`LCB_REG_STATUS, 32'h0000_0100, "attn pending");
        rd(`LCB_REG_ATTNCNT, 32'h0000_0001, "attn count");
        wr(`LCB_REG_STATUS, 32'h0000_0100);
        rd(`LCB_REG_STATUS, 32'h0000_0000, "attn clear");
        chk("selects idle", 32'h0000_0000, {31'h0, ownerSelects});
        wr(`LCB_REG_SEGBASE, 32'h89AB_0000);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`LCB_REG_CTRL, (i << 1) | ((i == 2) ? 8 : 0));
            repeat (2) @(negedge clk);
            v = (i == 0) ? 32'h00AB_2468 : (i == 1) ? 32'h89AB_2468 : 32'h1357_2468;
            chk("address", v, busAddrOut);
            chk("data", (i == 2) ? 32'h4433_2211 : 32'h1122_3344, busDataOut);
        end
        // A held hardware reset must keep the arbiter idle although work is pending.
        i_host.glue(32'h0000_0001, 1'b1);
        xferPending <= 1'b1;
        repeat (4) @(negedge clk);
        chk("held in reset", 32'h0000_0000, {31'h0, busRequest});
        i_host.glue(32'h0000_0000, 1'b0);
        waitOwn;
        @(posedge clk);
        xferPending <= 1'b0;
        waitIdle;
        summarize;
    end
endmodule
